// ==== hw/dmr_mode_regs.sv ====
// Module: mode-set decode and field logic for the second and third mode registers
//
// Operation
// - Mode-set to bank two loads write register
// - Bits 3..5 set write CAS delay
// - Total write delay is added plus CAS
// - Bits 9..10 select write termination
// - Write termination works without nominal termination
// - Write leveling uses nominal termination only
// - Bit 7 doubles the self refresh rate
// - Mode-set to bank three loads readout register
// - Bit 2 chooses array or pattern reads
// - Location bits ignored when pattern off
// - Pattern readout returns predefined pattern
//
// Behaviour in brief
// - A mode-set is taken on a rising clock edge with the clock enable high,
//   all four command strobes low and the bank bits equal to two or three.
// - The whole address word is stored as given; reserved positions are kept
//   and never checked, so a controller that breaks its own duty is not caught.
// - Every decoded output is registered from the next register image, so a
//   field shows its new value one edge after the command, never two.
// - Termination and read data follow their level inputs one cycle late.
// - While the clock enable is low nothing moves: commands are dropped and
//   every output holds its last value.
//
// Limitations
// - Refresh timing, temperature bands and self-refresh entry belong to the
//   controller; the block only reports the internal self refresh rate.
// - Reserved pattern locations read back the predefined pattern as well,
//   so a training loop never sees stale array data by mistake.
// - Write CAS code zero maps to the base delay held in the package; codes
//   above the supported set are passed through as a plain sum.
//
// Hazards
// - Outputs taken from the next image avoid a one-cycle lag after a
//   mode-set, at the cost of a longer path from the address pins.
// - The pattern beat phase restarts at zero whenever pattern readout is
//   switched off, so the first beat after enabling is always the high byte.
`timescale 1ns/10ps
`default_nettype none
module dmr_mode_regs #(
   parameter int DATA_W = 16
) (
   input wire logic mclk,                    // 10 MHz command clock
   input wire logic nrst,                    // Asynchronous active-low reset
   input wire logic clk_en,                  // Freezes all state while low
   input wire logic cs_n,                    // Chip select, active low
   input wire logic ras_n,                   // Row strobe, active low
   input wire logic cas_n,                   // Column strobe, active low
   input wire logic we_n,                    // Write enable, active low
   input wire logic [2:0] bank,              // Bank address BA2..BA0
   input wire logic [14:0] addr,             // Address pins A14..A0
   input wire logic [4:0] added_delay,       // Added delay from first mode register
   input wire logic nom_term_en,             // Nominal termination enabled
   input wire logic [2:0] nom_term_code,     // Nominal termination code
   input wire logic write_level_mode,        // Write leveling active
   input wire logic write_burst,             // Write burst in progress
   input wire logic [DATA_W-1:0] array_rdata, // Read data from the array
   output logic [2:0] write_cas_code,        // Stored write CAS delay code
   output logic [4:0] write_cas_delay,       // Write CAS delay in cycles
   output logic [5:0] total_write_delay,     // Added plus CAS delay in cycles
   output logic [1:0] write_termination,     // Stored dynamic termination code
   output logic term_active,                 // Termination is on now
   output logic [2:0] term_code,             // Termination code applied now
   output logic self_refresh_hot_mode,       // Stored hot mode bit
   output logic [1:0] sr_rate,               // Internal self refresh rate multiplier
   output logic pattern_readout_en,          // Reads come from pattern register
   output logic [1:0] pattern_loc,           // Effective pattern location
   output logic [DATA_W-1:0] read_data,      // Data returned on reads
   output logic read_beat_q                  // Beat phase for pattern output
);

   ////////////////////////////////////////////////////////////////////////////
   // Command decode

   // Mode-set: all four strobes low
   // Refresh, activate and the like never reach this decode: they differ
   // in at least one strobe, so only the mode-set pattern is matched here.
   wire logic mode_set_command;
   assign mode_set_command = ~cs_n & ~ras_n & ~cas_n & ~we_n;

   // Bank select for each register
   wire logic hit_odt_cwl;
   wire logic hit_readout;
   assign hit_odt_cwl = clk_en & mode_set_command & (bank == dmr_pkg::BANK_ODT_CWL);
   assign hit_readout = clk_en & mode_set_command & (bank == dmr_pkg::BANK_READOUT);

   ////////////////////////////////////////////////////////////////////////////
   // Register storage

   // Stored register images
   logic [14:0] odt_cwl_q;
   logic [14:0] odt_cwl_d;
   logic [14:0] readout_q;
   logic [14:0] readout_d;

   // Next values: load on own bank, otherwise hold
   // A command to the other bank leaves this image alone; one to banks zero and one leaves both alone.
   assign odt_cwl_d = hit_odt_cwl ? addr : odt_cwl_q;
   assign readout_d = hit_readout ? addr : readout_q;

   // Register images update only on their own mode-set
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         odt_cwl_q <= dmr_pkg::ODT_CWL_RST;
         readout_q <= dmr_pkg::READOUT_RST;
      end else begin
         odt_cwl_q <= odt_cwl_d;
         readout_q <= readout_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Field decode

   // Write CAS delay and total delay, whole cycles only
   wire logic [2:0] cwl_code_w;
   wire logic [4:0] cwl_cyc_w;
   wire logic [5:0] wl_cyc_w;
   assign cwl_code_w = odt_cwl_d[dmr_pkg::CWL_LSB +: dmr_pkg::CWL_W];
   assign cwl_cyc_w = dmr_pkg::CWL_BASE + {2'h0, cwl_code_w};
   assign wl_cyc_w = {1'b0, added_delay} + {1'b0, cwl_cyc_w};

   // Dynamic termination selection
   // Code zero means dynamic termination is off; nominal termination then
   // stays in force during bursts, which keeps a DLL-off setup safe.
   wire logic [1:0] wterm_w;
   wire logic wterm_use;
   wire logic term_on_w;
   wire logic [2:0] term_code_w;
   assign wterm_w = odt_cwl_d[dmr_pkg::WTERM_LSB +: dmr_pkg::WTERM_W];
   // Write termination applies in bursts, never while leveling
   assign wterm_use = write_burst & ~write_level_mode & (wterm_w != dmr_pkg::WTERM_OFF);
   assign term_on_w = wterm_use | nom_term_en;
   assign term_code_w = wterm_use ? {1'b0, wterm_w} : (nom_term_en ? nom_term_code : 3'h0);

   // Self refresh rate
   wire logic srt_w;
   assign srt_w = odt_cwl_d[dmr_pkg::SRT_BIT];
   wire logic [1:0] rate_w;
   assign rate_w = srt_w ? dmr_pkg::SR_RATE_2X : dmr_pkg::SR_RATE_1X;

   // Pattern readout control; location ignored when off
   wire logic src_w;
   wire logic [1:0] loc_w;
   assign src_w = readout_d[dmr_pkg::RD_SRC_BIT];
   assign loc_w = src_w ? readout_d[dmr_pkg::LOC_LSB +: dmr_pkg::LOC_W] : dmr_pkg::LOC_PREDEF;

   // Read data: predefined alternating pattern or array data
   // The pattern is the same on every byte lane so the capture logic can
   // train each lane from one known sequence.
   wire logic [DATA_W-1:0] pattern_w;
   wire logic [DATA_W-1:0] rdata_w;
   assign pattern_w = read_beat_q ? {(DATA_W/8){dmr_pkg::PATTERN_LO}}
                                  : {(DATA_W/8){dmr_pkg::PATTERN_HI}};
   // Reserved locations return the predefined pattern as well
   assign rdata_w = src_w ? pattern_w : array_rdata;

   ////////////////////////////////////////////////////////////////////////////
   // Output registers

   // All outputs come from flip-flops, frozen while the clock enable is low
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         write_cas_code <= 3'h0;
         write_cas_delay <= dmr_pkg::CWL_BASE;
         total_write_delay <= 6'h00;
         write_termination <= dmr_pkg::WTERM_OFF;
         term_active <= 1'b0;
         term_code <= 3'h0;
         self_refresh_hot_mode <= 1'b0;
         sr_rate <= dmr_pkg::SR_RATE_1X;
         pattern_readout_en <= 1'b0;
         pattern_loc <= dmr_pkg::LOC_PREDEF;
         read_data <= '0;
         read_beat_q <= 1'b0;
      end else if (clk_en) begin
         write_cas_code <= cwl_code_w;
         write_cas_delay <= cwl_cyc_w;
         total_write_delay <= wl_cyc_w;
         write_termination <= wterm_w;
         term_active <= term_on_w;
         term_code <= term_code_w;
         self_refresh_hot_mode <= srt_w;
         sr_rate <= rate_w;
         pattern_readout_en <= src_w;
         pattern_loc <= loc_w;
         read_data <= rdata_w;
         // Beat phase toggles while pattern readout runs
         read_beat_q <= src_w ? ~read_beat_q : 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   a_odt_cwl_load: assert property (@(posedge mclk) disable iff (!nrst)
      hit_odt_cwl |=> odt_cwl_q == $past(addr))
      else $error("refresh_odt_cwl_register not loaded");
   a_readout_load: assert property (@(posedge mclk) disable iff (!nrst)
      hit_readout |=> readout_q == $past(addr))
      else $error("readout_pattern_register not loaded");
   a_cwl_field: assert property (@(posedge mclk) disable iff (!nrst)
      hit_odt_cwl |=> write_cas_code == $past(addr[5:3]))
      else $error("write CAS code wrong");
   a_total_delay: assert property (@(posedge mclk) disable iff (!nrst)
      clk_en |=> total_write_delay == 6'($past(added_delay)) + 6'(write_cas_delay))
      else $error("total write delay wrong");
   a_wterm_field: assert property (@(posedge mclk) disable iff (!nrst)
      hit_odt_cwl |=> write_termination == $past(addr[10:9]))
      else $error("write termination field wrong");
   a_wterm_nomoff: assert property (@(posedge mclk) disable iff (!nrst)
      clk_en && write_burst && !write_level_mode && wterm_w != 2'h0
      |=> term_active && term_code == {1'b0, $past(wterm_w)})
      else $error("write termination not applied");
   a_level_nominal: assert property (@(posedge mclk) disable iff (!nrst)
      clk_en && write_level_mode |=> term_code == ($past(nom_term_en) ? $past(nom_term_code) : 3'h0))
      else $error("write termination used while leveling");
   a_srt_rate: assert property (@(posedge mclk) disable iff (!nrst)
      hit_odt_cwl |=> sr_rate == ($past(addr[7]) ? 2'h2 : 2'h1))
      else $error("self refresh rate wrong");
   a_read_source: assert property (@(posedge mclk) disable iff (!nrst)
      clk_en && !src_w |=> read_data == $past(array_rdata))
      else $error("array read not passed");
   a_loc_ignored: assert property (@(posedge mclk) disable iff (!nrst)
      clk_en && !src_w |=> pattern_loc == 2'h0)
      else $error("location not ignored");
   a_pattern_out: assert property (@(posedge mclk) disable iff (!nrst)
      clk_en && src_w |=> read_data == {DATA_W{!$past(read_beat_q)}})
      else $error("predefined pattern wrong");
   a_hold_value: assert property (@(posedge mclk) disable iff (!nrst)
      !hit_odt_cwl && !hit_readout |=> $stable(odt_cwl_q) && $stable(readout_q))
      else $error("mode register changed without mode-set");

   // Stored delay always equals base plus stored code
   a_cwl_sum: assert property (@(posedge mclk) disable iff (!nrst)
      write_cas_delay == dmr_pkg::CWL_BASE + {2'h0, write_cas_code})
      else $error("write CAS delay not base plus code");

   // Hot mode bit follows the loaded address bit
   a_srt_field: assert property (@(posedge mclk) disable iff (!nrst)
      hit_odt_cwl |=> self_refresh_hot_mode == $past(addr[7]))
      else $error("hot mode bit wrong");

   // Self refresh rate agrees with the stored hot mode bit
   a_rate_match: assert property (@(posedge mclk) disable iff (!nrst)
      sr_rate == (self_refresh_hot_mode ? 2'h2 : 2'h1))
      else $error("self refresh rate disagrees with hot mode");

   // Read source bit follows the loaded address bit
   a_src_field: assert property (@(posedge mclk) disable iff (!nrst)
      hit_readout |=> pattern_readout_en == $past(addr[2]))
      else $error("read source bit wrong");

   // Location is taken only while pattern readout is chosen
   a_loc_field: assert property (@(posedge mclk) disable iff (!nrst)
      hit_readout |=> pattern_loc == ($past(addr[2]) ? $past(addr[1:0]) : 2'h0))
      else $error("pattern location wrong");

   // Outside bursts only nominal termination is applied
   a_term_idle: assert property (@(posedge mclk) disable iff (!nrst)
      clk_en && !write_burst |=> term_active == $past(nom_term_en))
      else $error("termination outside burst wrong");

   // Leveling never turns write termination on by itself
   a_level_active: assert property (@(posedge mclk) disable iff (!nrst)
      clk_en && write_level_mode |=> term_active == $past(nom_term_en))
      else $error("termination active state wrong while leveling");

   // Beat phase rests at zero while array reads run
   a_beat_idle: assert property (@(posedge mclk) disable iff (!nrst)
      clk_en && !src_w |=> !read_beat_q)
      else $error("beat phase not idle");

   // Beat phase alternates while the pattern runs
   a_beat_toggle: assert property (@(posedge mclk) disable iff (!nrst)
      clk_en && src_w |=> read_beat_q != $past(read_beat_q))
      else $error("beat phase not alternating");

   // Frozen clock enable keeps the CAS code, termination, hot mode and read source fields still
   a_freeze_fields: assert property (@(posedge mclk) disable iff (!nrst)
      !clk_en |=> $stable(write_cas_code) && $stable(write_termination)
         && $stable(self_refresh_hot_mode) && $stable(pattern_readout_en))
      else $error("fields moved while clock enable low");

   // Frozen clock enable keeps the dynamic outputs still
   a_freeze_dyn: assert property (@(posedge mclk) disable iff (!nrst)
      !clk_en |=> $stable(read_data) && $stable(term_code)
         && $stable(total_write_delay))
      else $error("outputs moved while clock enable low");

endmodule : dmr_mode_regs
`default_nettype wire

// ==== hw/dmr_pkg.sv ====
// Package: constants for the second and third mode register block
package dmr_pkg;
   // Command decode: bank bits for the two registers
   localparam logic [2:0] BANK_ODT_CWL = 3'h2;
   localparam logic [2:0] BANK_READOUT = 3'h3;
   // Address width of the command bus
   localparam int ADDR_W = 15;
   // Field positions in refresh_odt_cwl_register
   localparam int CWL_LSB = 3;
   localparam int CWL_W = 3;
   localparam int SRT_BIT = 7;
   localparam int WTERM_LSB = 9;
   localparam int WTERM_W = 2;
   // Field positions in readout_pattern_register
   localparam int RD_SRC_BIT = 2;
   localparam int LOC_LSB = 0;
   localparam int LOC_W = 2;
   // Write CAS delay code 0 stands for five cycles
   localparam logic [4:0] CWL_BASE = 5'h05;
   // Reset values (nothing programmed)
   localparam logic [14:0] ODT_CWL_RST = 15'h0000;
   localparam logic [14:0] READOUT_RST = 15'h0000;
   // Predefined location code
   localparam logic [1:0] LOC_PREDEF = 2'h0;
   // Termination code meaning dynamic termination off
   localparam logic [1:0] WTERM_OFF = 2'h0;
   // Self refresh rate multipliers
   localparam logic [1:0] SR_RATE_1X = 2'h1;
   localparam logic [1:0] SR_RATE_2X = 2'h2;
   // Predefined training pattern bytes: alternating per beat
   localparam logic [7:0] PATTERN_HI = 8'hff;
   localparam logic [7:0] PATTERN_LO = 8'h00;
endpackage : dmr_pkg

// ==== testbench/dmr_ctl_model.sv ====
// Controller model that issues mode-set commands on the command bus
`timescale 1ns/10ps
`default_nettype none
module dmr_ctl_model (
   input wire logic mclk,
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic [2:0] bank,
   output logic [14:0] addr
);
   ////////////////////////////////////////////////////////////////////////////
   // Idle bus: strobes high, no command
   initial begin
      {cs_n, ras_n, cas_n, we_n} = 4'hf;
      bank = 3'h0;
      addr = 15'h0000;
   end

   // Controller duties kept by construction: it runs at normal temperature,
   // issues no self refresh and no refresh burst, so rate, hot-mode entry
   // and interval limits never apply; the DLL stays on, so termination
   // code zero is only chosen freely, never forced

   ////////////////////////////////////////////////////////////////////////////
   // One command, launched on a falling edge and taken on the next rising edge
   task automatic mode_set(input logic [2:0] b, input logic [14:0] a);
      @(negedge mclk);
      {cs_n, ras_n, cas_n, we_n} = 4'h0;
      bank = b & 3'h3;
      addr = (b == 3'h3) ? (a & 15'h0007) : (a & 15'h06ff);
      @(negedge mclk);
      // Released lines show a changing pattern, never the last value
      {cs_n, ras_n, cas_n, we_n} = 4'hf;
      bank = ~bank;
      addr = ~addr;
   endtask : mode_set
endmodule : dmr_ctl_model
`default_nettype wire

// ==== testbench/dram_mode_reg_two_three_tb.sv ====
// Self-checking bench for the second and third mode register block
`timescale 1ns/10ps
`default_nettype none
module dram_mode_reg_two_three_tb;
   logic mclk, nrst, clk_en, cs_n, ras_n, cas_n, we_n, nom_term_en, write_level_mode;
   logic write_burst, term_active, self_refresh_hot_mode, pattern_readout_en, read_beat_q;
   logic [2:0] bank, nom_term_code, write_cas_code, term_code;
   logic [14:0] addr;
   logic [4:0] added_delay, write_cas_delay;
   logic [5:0] total_write_delay;
   logic [1:0] write_termination, sr_rate, pattern_loc;
   logic [15:0] array_rdata, read_data;
   int r2, r3, err_count, total_checks, seed, i, j, wt, ea, ec; // Model images and counters

   ////////////////////////////////////////////////////////////////////////////
   // Design, controller model and clock
   dmr_mode_regs #(.DATA_W(16)) u_dut (.mclk, .nrst, .clk_en, .cs_n, .ras_n, .cas_n, .we_n,
      .bank, .addr, .added_delay, .nom_term_en, .nom_term_code, .write_level_mode,
      .write_burst, .array_rdata, .write_cas_code, .write_cas_delay, .total_write_delay,
      .write_termination, .term_active, .term_code, .self_refresh_hot_mode, .sr_rate,
      .pattern_readout_en, .pattern_loc, .read_data, .read_beat_q);
   dmr_ctl_model u_ctl (.mclk, .cs_n, .ras_n, .cas_n, .we_n, .bank, .addr);
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Compare, verdict and register model
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_of_test
   task automatic check_regs();
      chk("write_cas_code", write_cas_code, 16'(r2 >> 3 & 7));
      chk("write_cas_delay", write_cas_delay, 16'(5 + (r2 >> 3 & 7)));
      chk("total_write_delay", total_write_delay, 16'(added_delay + 5 + (r2 >> 3 & 7)));
      chk("write_termination", write_termination, 16'(r2 >> 9 & 3));
      chk("self_refresh_hot_mode", self_refresh_hot_mode, 16'(r2 >> 7 & 1));
      chk("sr_rate", sr_rate, 16'((r2 >> 7 & 1) + 1));
      chk("pattern_readout_en", pattern_readout_en, 16'(r3 >> 2 & 1));
      chk("pattern_loc", pattern_loc, 16'((r3 >> 2 & 1) ? (r3 & 3) : 0));
   endtask : check_regs
   // Issue a command, update the model only when it is taken, then compare
   task automatic cmd(input int b, input int a);
      u_ctl.mode_set(3'(b), 15'(a));
      if (clk_en && b == 2) r2 = a & 'h6ff;
      if (clk_en && b == 3) r3 = a & 7;
      check_regs();
   endtask : cmd

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      seed = 32'h399ab3b7;
      {nrst, added_delay, nom_term_en, nom_term_code, write_level_mode, write_burst} = '0;
      {clk_en, array_rdata, r2, r3, err_count, total_checks} = {1'b1, 16'h0000, 128'h0};
      repeat (5) @(negedge mclk);
      nrst = 1'b1;
      @(negedge mclk);
      check_regs();
      // Every write CAS code with random added delay and other fields
      for (i = 0; i < 8; i++) begin
         added_delay = 5'($random(seed));
         cmd(2, ($random(seed) & 'h6c7) | (i << 3));
      end
      cmd(0, 'h7ff);
      cmd(1, 'h6ff);
      clk_en = 1'b0;
      cmd(2, 'h0);
      clk_en = 1'b1;
      // Termination choice over every burst, leveling and nominal-enable combination, write termination off or code one
      for (i = 0; i < 16; i++) begin
         cmd(2, (i & 8) ? 'h200 : 'h0);
         {write_burst, write_level_mode, nom_term_en} = 3'(i);
         nom_term_code = 3'($random(seed));
         @(negedge mclk);
         wt = (write_burst && !write_level_mode && (i & 8)) ? 1 : 0;
         ea = wt || nom_term_en;
         ec = wt ? 1 : (nom_term_en ? nom_term_code : 0);
         chk("term_active", term_active, 16'(ea));
         chk("term_code", term_code, 16'(ec));
      end
      // Array reads with pattern off, then the pattern at every location code
      for (i = 0; i < 4; i++) begin
         cmd(3, i);
         array_rdata = 16'($random(seed));
         @(negedge mclk);
         chk("read_data", read_data, array_rdata);
         cmd(3, 4 + i);
         for (j = 0; j < 4; j++) begin
            chk("read_data", read_data, (j & 1) ? 16'h0000 : 16'hffff);
            @(negedge mclk);
         end
      end
      // Reset in mid-run clears both images back to unprogrammed
      nrst = 1'b0;
      repeat (2) @(negedge mclk);
      {r2, r3} = '0;
      nrst = 1'b1;
      @(negedge mclk);
      check_regs();
      end_of_test();
   end

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog cuts a hang short
   initial begin
      #(100 * 2000);
      err_count++;
      end_of_test();
   end
endmodule : dram_mode_reg_two_three_tb
`default_nettype wire
